//--- e1pm_line_model.sv
// Purpose: Line terminal model that feeds framer events to the monitor.
// Assumes: A burst of n_i CRC-4 blocks starts the cycle after go_i.
// Notes:   Matching blocks show that only mismatched blocks count.
`default_nettype none
module e1pm_line_model (
  input  wire logic             clk_i,
  input  wire logic             go_i,
  input  wire logic [9:0]       n_i,
  input  wire logic             bad_i,
  input  wire logic             nosig_i,
  input  wire logic             eb_i,
  output var e1pm_pkg::frm_ev_t frm_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import e1pm_pkg::*;
  logic [9:0] left_q = 10'h000;
  always @(posedge clk_i) begin
    if (go_i)
      left_q <= n_i;
    else if (left_q != 10'h000)
      left_q <= left_q - 10'h001;
  end
  always_comb begin
    frm_o          = '0;
    frm_o.blk_stb  = left_q != 10'h000;
    frm_o.crc_calc = 4'h6;
    frm_o.crc_rx   = bad_i ? 4'h9 : 4'h6;
    frm_o.ebit      = eb_i && (left_q != 10'h000);
    frm_o.no_signal = nosig_i;
  end
endmodule : e1pm_line_model
`default_nettype wire

//--- e1pm_mon.sv
// Purpose: In-service quality monitor of one framed E1 port.
// Assumes: Framer strobes are synchronous one-cycle pulses.
// Notes:   Seconds are evaluated after a ten second delay line.
//
// Local design decisions: the address map and the Wishbone register port.

`default_nettype none

module e1pm_mon #(
  parameter int CPS = e1pm_pkg::CYC_PER_SEC
) (
  input  wire logic              REF_CLK_I,
  input  wire logic              RST_I,
  input  wire logic              CYC_I,
  input  wire logic              STB_I,
  input  wire logic              WE_I,
  input  wire logic [7:0]        ADR_I,
  input  wire logic [3:0]        SEL_I,
  input  wire logic [31:0]       DAT_I,
  output logic      [31:0]       DAT_O,
  output logic                   ACK_O,
  input  wire e1pm_pkg::frm_ev_t FRM_I,
  output logic                   REPORT_O,
  output logic                   UNAVAIL_O,
  output logic                   SEC_TICK_O
);
  import e1pm_pkg::*;

  localparam logic [31:0] CPS_M1 = 32'(CPS - 1);

  typedef struct packed {
    logic [31:0]                cyc;
    logic [9:0]                 sq;
    logic [6:0]                 qd;
    logic [31:0]                secs;
    logic [9:0]                 crc;
    logic [9:0]                 eb;
    logic [9:0]                 ab;
    logic                       align_loss;
    logic                       no_signal;
    logic                       sa;
    sec_t [UNAV_RUN-1:0]        pipe;
    logic                       ux;
    logic                       tx_unav;
    logic                       proc;
    logic                       qb;
    logic                       db;
    logic                       hyst;
    logic                       txm;
    logic [31:0]                lqe;
    logic [31:0]                lqs;
    logic [31:0]                wl;
    logic [31:0]                lde;
    logic [31:0]                lds;
    logic [9:0]                 athr;
    logic [31:0]                cqe;
    logic [31:0]                cqs;
    logic [31:0]                cde;
    logic [31:0]                cds;
    logic                       he;
    logic                       hs;
    logic [N_REP-1:0]           rep;
    logic [N_REP-1:0][31:0]     stamp;
    logic [15:0]                loge;
    logic [15:0]                logs;
    logic [31:0]                tav;
    logic [31:0]                tes;
    logic [31:0]                tss;
    logic [31:0]                tbb;
    dv_t                        dv;
    logic [32:0]                rem;
    logic [31:0]                den;
    logic [15:0]                quo;
    logic [3:0]                 dn;
    logic [15:0]                ratio;
    logic                       ack;
    logic [31:0]                dat;
  } st_t;

  st_t                 q;
  st_t                 d;
  sec_t                ne;
  sec_t [UNAV_RUN-1:0] npipe;
  logic [UNAV_RUN-1:0] rs;
  logic [UNAV_RUN-1:0] rn;
  logic [UNAV_RUN-1:0] ts;
  logic [UNAV_RUN-1:0] tn;
  logic                tick;
  logic                cerr;
  logic                abit;
  logic                pav;
  logic                req;
  logic                ok;
  logic                err_sec;
  logic                ss;
  logic [31:0]         nqe;
  logic [31:0]         nqs;
  logic [31:0]         nde;
  logic [31:0]         nds;
  logic [31:0]         wlv;
  logic [31:0]         num;
  logic [31:0]         dnm;
  logic [32:0]         r2;
  logic [31:0]         rd;
  logic [N_REP-1:0]    setv;
  sec_t                o;

  function automatic logic [9:0] inc10(input logic [9:0] v,
                                       input logic e);
    return (e && v != SAT10) ? v + 10'h1 : v;
  endfunction : inc10

  function automatic logic [31:0] mrg(input logic [31:0] old,
                                      input logic [31:0] nw,
                                      input logic [3:0]  sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~m) | (nw & m);
  endfunction : mrg

  ////////////////////////////////////////////////////////////////////////////
  // Elementary events and the classification of the closing second.

  assign tick = (q.cyc == CPS_M1);
  assign cerr = FRM_I.blk_stb && (FRM_I.crc_calc != FRM_I.crc_rx);
  assign abit = FRM_I.nonalign_stb && FRM_I.nonalign[ABIT_POS];

  always_comb begin
    ne      = '0;
    ne.v    = 1'b1;
    ne.crc  = q.crc;
    ne.rses = q.align_loss || q.no_signal || (q.crc >= 10'(RX_SES_CRC));
    ne.res  = ne.rses || (q.crc != 10'h0);
    // Transmit seconds stay normal unless that direction is monitored.
    ne.tses = q.txm && ((q.eb >= 10'(TX_SES_EB)) ||
                        (q.athr != 10'h0 && q.ab >= q.athr));
    ne.tes  = ne.tses || (q.txm && (q.eb != 10'h0 ||
                                    q.ab != 10'h0 || q.sa));
  end

  assign npipe = {q.pipe[UNAV_RUN-2:0], ne};

  genvar gi;
  generate
    for (gi = 0; gi < UNAV_RUN; gi++) begin : g_win
      assign rs[gi] = npipe[gi].v && npipe[gi].rses;
      assign rn[gi] = npipe[gi].v && !npipe[gi].rses;
      assign ts[gi] = npipe[gi].v && npipe[gi].tses;
      assign tn[gi] = npipe[gi].v && !npipe[gi].tses;
    end
  endgenerate

  assign pav = !(q.ux || q.tx_unav);
  assign o   = q.pipe[UNAV_RUN-1];
  assign ok  = q.proc && o.v && pav;
  assign err_sec = o.res || o.tes;
  assign ss  = o.rses || o.tses;
  assign nqe = q.cqe + {31'h0, ok && err_sec};
  assign nqs = q.cqs + {31'h0, ok && ss};
  assign nde = q.cde + {31'h0, ok && err_sec};
  assign nds = q.cds + {31'h0, ok && ss};
  assign wlv = (q.wl > q.lqe) ? q.lqe : q.wl;
  assign req = CYC_I && STB_I && !q.ack;
  assign r2  = {q.rem[31:0], 1'b0};

  ////////////////////////////////////////////////////////////////////////////
  // Register read multiplexer.

  always_comb begin
    rd  = 32'h0;
    num = q.tes;
    dnm = q.tav;
    case (DAT_I[1:0])
      2'h1: num = q.tss;
      2'h2: begin
        num = q.tbb;
        dnm = 32'((q.tav - q.tss) * BLK_PER_SEC);
      end
      default: num = q.tes;
    endcase
    case (ADR_I)
      OFS_CTRL:  rd = {30'h0, q.txm, q.hyst};
      OFS_LQE:   rd = q.lqe;
      OFS_LQS:   rd = q.lqs;
      OFS_WLVL:  rd = q.wl;
      OFS_LDE:   rd = q.lde;
      OFS_LDS:   rd = q.lds;
      OFS_ATHR:  rd = {22'h0, q.athr};
      OFS_STAT:  rd = {28'h0, q.dv == DV_RUN, !pav, q.tx_unav, q.ux};
      OFS_CQE:   rd = q.cqe;
      OFS_CQS:   rd = q.cqs;
      OFS_CDE:   rd = q.cde;
      OFS_CDS:   rd = q.cds;
      OFS_REP:   rd = {25'h0, q.rep};
      OFS_SECS:  rd = q.secs;
      OFS_LOG:   rd = {q.logs, q.loge};
      OFS_RATIO: rd = {16'h0, q.ratio};
      OFS_TAV:   rd = q.tav;
      OFS_TES:   rd = q.tes;
      OFS_TSS:   rd = q.tss;
      OFS_TBB:   rd = q.tbb;
      default: begin
        if (ADR_I[7:5] == OFS_STAMP3 && ADR_I[4:2] < 3'(N_REP)) begin
          rd = q.stamp[ADR_I[4:2]];
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  always_comb begin
    d     = q;
    setv  = '0;
    d.ack = 1'b0;
    d.cyc = tick ? 32'h0 : q.cyc + 32'h1;
    d.proc = tick;
    d.qb  = 1'b0;
    d.db  = 1'b0;
    if (tick) begin
      d.secs = q.secs + 32'h1;
      d.sq   = (q.sq == 10'(QH_SECS - 1)) ? 10'h0 : q.sq + 10'h1;
      d.qb   = (q.sq == 10'(QH_SECS - 1));
      if (d.qb) begin
        d.qd = (q.qd == 7'(DAY_QH - 1)) ? 7'h0 : q.qd + 7'h1;
        d.db = (q.qd == 7'(DAY_QH - 1));
      end
    end

    // An event in the tick cycle already belongs to the new second.
    d.crc = inc10(tick ? 10'h0 : q.crc, cerr);
    d.eb  = inc10(tick ? 10'h0 : q.eb, FRM_I.ebit);
    d.ab  = inc10(tick ? 10'h0 : q.ab, abit);
    d.align_loss = (!tick && q.align_loss) || FRM_I.align_loss;
    d.no_signal  = (!tick && q.no_signal) || FRM_I.no_signal;
    d.sa  = (!tick && q.sa) || FRM_I.sa;

    // The window ends with the second that leaves the delay line next, so
    // that whole run of severe seconds is already counted as unavailable.
    if (tick) begin
      d.pipe = npipe;
      if (!q.ux && (&rs)) begin
        d.ux = 1'b1;
      end else if (q.ux && (&rn)) begin
        d.ux = 1'b0;
      end
      if (!q.tx_unav && (&ts)) begin
        d.tx_unav = 1'b1;
      end else if (q.tx_unav && (&tn)) begin
        d.tx_unav = 1'b0;
      end
    end

    d.cqe = nqe;
    d.cqs = nqs;
    d.cde = nde;
    d.cds = nds;
    if (ok) begin
      d.tav = q.tav + 32'h1;
      d.tes = q.tes + {31'h0, err_sec};
      d.tss = q.tss + {31'h0, ss};
      if (!ss) begin
        d.tbb = q.tbb + {22'h0, o.crc};
      end
    end

    if (nqe > q.lqe && q.cqe <= q.lqe) begin
      if (!q.hyst) begin
        setv[RP_QE_UP] = 1'b1;
      end else if (!q.he) begin
        setv[RP_QE_UP] = 1'b1;
        d.he = 1'b1;
      end
    end
    if (nqs > q.lqs && q.cqs <= q.lqs) begin
      if (!q.hyst) begin
        setv[RP_QS_UP] = 1'b1;
      end else if (!q.hs) begin
        setv[RP_QS_UP] = 1'b1;
        d.hs = 1'b1;
      end
    end
    if (nde > q.lde && q.cde <= q.lde) begin
      setv[RP_DE] = 1'b1;
    end
    if (nds > q.lds && q.cds <= q.lds) begin
      setv[RP_DS] = 1'b1;
    end

    if (q.proc && q.qb) begin
      if (!q.hyst) begin
        setv[RP_LOG] = 1'b1;
        d.loge = nqe[15:0];
        d.logs = nqs[15:0];
      end else begin
        if (q.he && nqe <= wlv) begin
          setv[RP_QE_RST] = 1'b1;
          d.he = 1'b0;
        end
        if (q.hs && nqs == 32'h0) begin
          setv[RP_QS_RST] = 1'b1;
          d.hs = 1'b0;
        end
      end
      d.cqe = 32'h0;
      d.cqs = 32'h0;
    end
    if (q.proc && q.db) begin
      d.cde = 32'h0;
      d.cds = 32'h0;
    end

    for (int k = 0; k < N_REP; k++) begin
      if (setv[k]) begin
        d.stamp[k] = q.secs;
      end
    end

    // Restoring division gives a ratio as a 16-bit binary fraction.
    case (q.dv)
      DV_RUN: begin
        if (r2 >= {1'b0, q.den}) begin
          d.rem = r2 - {1'b0, q.den};
          d.quo = {q.quo[14:0], 1'b1};
        end else begin
          d.rem = r2;
          d.quo = {q.quo[14:0], 1'b0};
        end
        d.dn = q.dn - 4'h1;
        if (q.dn == 4'h0) begin
          d.ratio = d.quo;
          d.dv    = DV_IDLE;
        end
      end
      default: d.dv = DV_IDLE;
    endcase

    d.rep = q.rep | setv;
    if (req) begin
      d.ack = 1'b1;
      d.dat = WE_I ? q.dat : rd;
      if (WE_I) begin
        case (ADR_I)
          OFS_CTRL: begin
            if (SEL_I[0]) begin
              d.hyst = DAT_I[CTRL_HYST];
              d.txm  = DAT_I[CTRL_TXM];
            end
          end
          OFS_LQE:  d.lqe = mrg(q.lqe, DAT_I, SEL_I);
          OFS_LQS:  d.lqs = mrg(q.lqs, DAT_I, SEL_I);
          OFS_WLVL: d.wl  = mrg(q.wl, DAT_I, SEL_I);
          OFS_LDE:  d.lde = mrg(q.lde, DAT_I, SEL_I);
          OFS_LDS:  d.lds = mrg(q.lds, DAT_I, SEL_I);
          OFS_ATHR: d.athr = 10'(mrg({22'h0, q.athr}, DAT_I, SEL_I));
          OFS_REP: begin
            // Set wins: a report raised in this cycle survives the clear.
            if (SEL_I[0]) begin
              d.rep = (q.rep & ~DAT_I[N_REP-1:0]) | setv;
            end
          end
          OFS_RATIO: begin
            if (SEL_I[0] && q.dv == DV_IDLE) begin
              if (dnm == 32'h0) begin
                d.ratio = 16'h0;
              end else if (num >= dnm) begin
                d.ratio = 16'hffff;
              end else begin
                d.rem = {1'b0, num};
                d.den = dnm;
                d.quo = 16'h0;
                d.dn  = 4'hf;
                d.dv  = DV_RUN;
              end
            end
          end
          default: d.dat = q.dat;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      q      <= '0;
      q.lqe  <= LQE_RST;
      q.lqs  <= LQS_RST;
      q.wl   <= WLVL_RST;
      q.lde  <= LDE_RST;
      q.lds  <= LDS_RST;
      q.athr <= ATHR_RST;
      q.dv   <= DV_IDLE;
    end else begin
      q <= d;
    end
  end

  assign DAT_O      = q.dat;
  assign ACK_O      = q.ack;
  assign REPORT_O   = |q.rep;
  assign UNAVAIL_O  = q.ux || q.tx_unav;
  assign SEC_TICK_O = q.proc;

  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);

  property p_crc;
    cerr && !tick && q.crc != SAT10 |=> q.crc == $past(q.crc) + 10'h1;
  endproperty
  a_crc: assert property (p_crc) else $error("CRC error not counted");

  property p_ebit;
    FRM_I.ebit && !tick && q.eb != SAT10 |=> q.eb == $past(q.eb) + 10'h1;
  endproperty
  a_ebit: assert property (p_ebit) else $error("E bit not counted");

  property p_defect;
    (FRM_I.align_loss || FRM_I.no_signal) && !tick |=>
      q.align_loss || q.no_signal;
  endproperty
  a_defect: assert property (p_defect) else $error("Defect lost");

  property p_abit;
    abit && !tick && q.ab != SAT10 |=> q.ab == $past(q.ab) + 10'h1;
  endproperty
  a_abit: assert property (p_abit) else $error("A bit not counted");

  property p_rxses;
    tick && q.crc >= 10'(RX_SES_CRC) |=> q.pipe[0].rses && q.pipe[0].res;
  endproperty
  a_rxses: assert property (p_rxses) else $error("Severe rx missed");

  property p_txses;
    tick && q.txm && q.eb >= 10'(TX_SES_EB) |=> q.pipe[0].tses;
  endproperty
  a_txses: assert property (p_txses) else $error("Severe tx missed");

  property p_unav;
    tick && !q.ux && (&rs) |=> q.ux && !ok;
  endproperty
  a_unav: assert property (p_unav) else $error("No unavailable");

  property p_hold;
    q.proc && !pav |=> $stable(q.tav) && $stable(q.tes);
  endproperty
  a_hold: assert property (p_hold) else $error("Counted while down");

  property p_qclr;
    q.proc && q.qb |=> q.cqe == 32'h0 && q.cqs == 32'h0;
  endproperty
  a_qclr: assert property (p_qclr) else $error("Quarter not cleared");

  property p_log;
    q.proc && q.qb && !q.hyst |=>
      q.rep[RP_LOG] && {16'h0, q.loge} == ($past(nqe) & 32'h0000_ffff);
  endproperty
  a_log: assert property (p_log) else $error("Quarter log missing");

  property p_day;
    q.proc && q.db |=> q.cde == 32'h0 && q.cds == 32'h0;
  endproperty
  a_day: assert property (p_day) else $error("Day not cleared");

  property p_tick;
    tick |=> q.proc ##1 !q.proc;
  endproperty
  a_tick: assert property (p_tick) else $error("Bad second strobe");

  c_unav:  cover property (!q.ux ##1 q.ux);
  c_raise: cover property (setv[RP_QE_UP]);
  c_reset: cover property (setv[RP_QE_RST]);
  c_div:   cover property (q.dv == DV_RUN ##1 q.dv == DV_IDLE);

endmodule : e1pm_mon

`default_nettype wire

//--- e1pm_pkg.sv
// Purpose: Shared constants and types of the E1 path quality monitor.
// Assumes: 25 MHz reference clock, one monitored 2 048 kbit/s port.
// Notes:   Register offsets are byte addresses on a 32-bit Wishbone.

`default_nettype none

package e1pm_pkg;

  //////////////////////////////////////////////////////////////////////////
  localparam int CLK_HZ      = 25_000_000;
  localparam int SEC_S       = 1;
  localparam int CYC_PER_SEC = CLK_HZ * SEC_S;
  localparam int QH_MIN      = 15;
  localparam int QH_SECS     = QH_MIN * 60;
  localparam int DAY_H       = 24;
  localparam int DAY_QH      = DAY_H * 60 / QH_MIN;
  localparam int UNAV_RUN    = 10;
  localparam int RX_SES_CRC  = 805;
  localparam int TX_SES_EB   = 830;
  localparam int BLK_PER_SEC = 1000;
  localparam int ABIT_POS    = 5;
  localparam logic [9:0] SAT10 = 10'h3ff;

  //////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_LQE    = 8'h04;
  localparam logic [7:0] OFS_LQS    = 8'h08;
  localparam logic [7:0] OFS_WLVL   = 8'h0c;
  localparam logic [7:0] OFS_LDE    = 8'h10;
  localparam logic [7:0] OFS_LDS    = 8'h14;
  localparam logic [7:0] OFS_ATHR   = 8'h18;
  localparam logic [7:0] OFS_STAT   = 8'h1c;
  localparam logic [7:0] OFS_CQE    = 8'h20;
  localparam logic [7:0] OFS_CQS    = 8'h24;
  localparam logic [7:0] OFS_CDE    = 8'h28;
  localparam logic [7:0] OFS_CDS    = 8'h2c;
  localparam logic [7:0] OFS_REP    = 8'h30;
  localparam logic [7:0] OFS_SECS   = 8'h34;
  localparam logic [7:0] OFS_LOG    = 8'h38;
  localparam logic [7:0] OFS_RATIO  = 8'h3c;
  localparam logic [2:0] OFS_STAMP3 = 3'h2;
  localparam logic [7:0] OFS_TAV    = 8'h60;
  localparam logic [7:0] OFS_TES    = 8'h64;
  localparam logic [7:0] OFS_TSS    = 8'h68;
  localparam logic [7:0] OFS_TBB    = 8'h6c;

  localparam int CTRL_HYST = 0;
  localparam int CTRL_TXM  = 1;
  localparam logic [31:0] LQE_RST  = 32'h0000_0064;
  localparam logic [31:0] LQS_RST  = 32'h0000_000a;
  localparam logic [31:0] WLVL_RST = 32'h0000_0032;
  localparam logic [31:0] LDE_RST  = 32'h0000_03e8;
  localparam logic [31:0] LDS_RST  = 32'h0000_0064;
  localparam logic [9:0]  ATHR_RST = 10'h00a;

  localparam int RP_QE_UP  = 0;
  localparam int RP_QS_UP  = 1;
  localparam int RP_QE_RST = 2;
  localparam int RP_QS_RST = 3;
  localparam int RP_LOG    = 4;
  localparam int RP_DE     = 5;
  localparam int RP_DS     = 6;
  localparam int N_REP     = 7;

  //////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic       blk_stb;
    logic [3:0] crc_calc;
    logic [3:0] crc_rx;
    logic       ebit;
    logic       nonalign_stb;
    logic [7:0] nonalign;
    logic       sa;
    logic       align_loss;
    logic       no_signal;
  } frm_ev_t;

  typedef struct packed {
    logic       v;
    logic       res;
    logic       rses;
    logic       tes;
    logic       tses;
    logic [9:0] crc;
  } sec_t;

  typedef enum logic {DV_IDLE, DV_RUN} dv_t;

endpackage : e1pm_pkg

`default_nettype wire

//--- test_e1_path_performance_monitor.sv
// Purpose: Self-checking bench of the path quality monitor.
// Assumes: A short second of CPS cycles keeps the run brief.
// Notes:   Quarter and day boundaries lie beyond the run length.
`default_nettype none
module test_e1_path_performance_monitor;
  timeunit 1ns;
  timeprecision 1ns;
  import e1pm_pkg::*;
  localparam int CPS = 1000;
  logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic        go = 1'b0, bad = 1'b0, nosig = 1'b0, ebt = 1'b0;
  logic        ack, report, unav, tick;
  logic [7:0]  adr = 8'h00;
  logic [9:0]  nblk = 10'h000;
  logic [31:0] wdat = 32'h0, dout, rdat;
  frm_ev_t     frm;
  int          n_mismatch = 0, checks_done = 0, cyc_cnt = 0;

  always #20 clk = ~clk;

  e1pm_line_model u_line (.clk_i(clk), .go_i(go), .n_i(nblk), .bad_i(bad),
                          .nosig_i(nosig), .eb_i(ebt), .frm_o(frm));
  e1pm_mon #(.CPS(CPS)) u_dut (.REF_CLK_I(clk), .RST_I(rst), .CYC_I(cyc),
    .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(4'hf), .DAT_I(wdat),
    .DAT_O(dout), .ACK_O(ack), .FRM_I(frm), .REPORT_O(report),
    .UNAVAIL_O(unav), .SEC_TICK_O(tick));

  //////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // The request is held until ack is sampled, then released for a cycle.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rdat = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic tick_wait;
    do @(posedge clk); while (tick !== 1'b1);
  endtask : tick_wait

  task automatic burst(input logic [9:0] n, input logic b);
    tick_wait;
    go   <= 1'b1;
    nblk <= n;
    bad  <= b;
    @(posedge clk);
    go <= 1'b0;
  endtask : burst

  //////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [7:0]  ofs [7] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h7c};
    logic [31:0] ev [7]  = '{32'h64, 32'ha, 32'h32, 32'h3e8, 32'h64, 32'ha,
                             32'h0};
    for (int i = 0; i < 7; i++) begin
      wb(1'b0, ofs[i], 32'h0);
      chk("reset value", ev[i], rdat);
    end
    wb(1'b1, 8'h18, 32'h123);
    wb(1'b0, 8'h18, 32'h0);
    chk("alarm threshold", 32'h123, rdat);
  endtask : t_regs

  task automatic t_tick;
    int n;
    tick_wait;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (tick !== 1'b1);
    chk("second length", CPS, n);
  endtask : t_tick

  // Boundary: 804 block errors stay errored only, 805 make a severe second.
  task automatic t_classify;
    wb(1'b1, 8'h04, 32'h1);
    burst(10'h384, 1'b0);
    burst(10'h324, 1'b1);
    burst(10'h325, 1'b1);
    repeat (12) tick_wait;
    wb(1'b0, 8'h20, 32'h0);
    chk("quarter errored", 32'h2, rdat);
    wb(1'b0, 8'h24, 32'h0);
    chk("quarter severe", 32'h1, rdat);
    wb(1'b0, 8'h2c, 32'h0);
    chk("daily severe", 32'h1, rdat);
    chk("report line", 32'h1, {31'h0, report});
    wb(1'b0, 8'h30, 32'h0);
    chk("pending reports", 32'h1, rdat);
    wb(1'b1, 8'h30, 32'h7f);
    chk("report cleared", 32'h0, {31'h0, report});
  endtask : t_classify

  // Boundary: 829 far-end errors stay errored only, 830 make it severe.
  task automatic t_tx;
    wb(1'b1, 8'h00, 32'h2);
    ebt <= 1'b1;
    burst(10'h33d, 1'b0);
    burst(10'h33e, 1'b0);
    tick_wait;
    ebt <= 1'b0;
    repeat (11) tick_wait;
    wb(1'b0, 8'h20, 32'h0);
    chk("tx errored", 32'h4, rdat);
    wb(1'b0, 8'h24, 32'h0);
    chk("tx severe", 32'h2, rdat);
    chk("no repeat report", 32'h0, {31'h0, report});
  endtask : t_tx

  task automatic t_unavail;
    int n;
    tick_wait;
    nosig <= 1'b1;
    n = 0;
    while (unav !== 1'b1 && n < 25) begin
      tick_wait;
      n++;
    end
    chk("unavailable", 32'h1, {31'h0, unav});
    wb(1'b0, 8'h1c, 32'h0);
    chk("path status", 32'h1, {31'h0, rdat[2]});
    wb(1'b0, 8'h24, 32'h0);
    chk("severe held", 32'h2, rdat);
    nosig <= 1'b0;
  endtask : t_unavail

  //////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 80000) begin
      n_mismatch++;
      complete_run;
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_tick;
    t_classify;
    t_tx;
    t_unavail;
    complete_run;
  end
endmodule : test_e1_path_performance_monitor
`default_nettype wire
